// ### rtl/seq_cfg_pkg.sv
// constants for the sequencer configuration bank: register indices, reset values,
// field positions and bus answer codes.
// assumes nothing of its surroundings; every design file imports it.
`default_nettype none

package seq_cfg_pkg;

    localparam int DATA_W    = 16;
    localparam int IDX_W     = 3;
    localparam int REG_COUNT = 7;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_GENERAL  = 3'h0;
    localparam logic [IDX_W-1:0] IDX_DELAY    = 3'h1;
    localparam logic [IDX_W-1:0] IDX_INTEG    = 3'h2;
    localparam logic [IDX_W-1:0] IDX_WINDOW   = 3'h3;
    localparam logic [IDX_W-1:0] IDX_SPARE    = 3'h4;
    localparam logic [IDX_W-1:0] IDX_DARK     = 3'h5;
    localparam logic [IDX_W-1:0] IDX_PADDING  = 3'h6;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_GENERAL = 16'h0000;
    localparam logic [DATA_W-1:0] RST_DELAY   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_INTEG   = 16'h0004;
    localparam logic [DATA_W-1:0] RST_WINDOW  = 16'h0001;
    localparam logic [DATA_W-1:0] RST_SPARE   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_DARK    = 16'h0102;
    localparam logic [DATA_W-1:0] RST_PADDING = 16'h0000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int GEN_ENABLE_BIT    = 0;
    localparam int GEN_ROLLING_BIT   = 1;
    localparam int GEN_DELAY_EN_BIT  = 6;
    localparam int GEN_SUBSAMPLE_BIT = 7;
    localparam int GEN_BINNING_BIT   = 8;
    localparam int GEN_AEC_WIN_BIT   = 10;
    localparam int GEN_MON_LSB       = 11;
    localparam int MON_W             = 3;
    localparam int BYTE_W            = 8;
    localparam int DLY_EXT_LSB       = 0;
    localparam int DLY_WAIT_LSB      = 8;
    localparam int INT_DUAL_BIT      = 0;
    localparam int INT_TRIPLE_BIT    = 1;
    localparam int INT_LEN_SEL_BIT   = 2;
    localparam int WIN_LSB           = 0;
    localparam int DARK_COUNT_LSB    = 0;
    localparam int DARK_BLANK_BIT    = 8;
    localparam int PAD_LSB           = 0;
    localparam int PAD_W             = 12;

    localparam logic [BYTE_W-1:0] DARK_MIN = 8'h01;
    localparam logic [PAD_W-1:0]  PAD_MAX  = 12'h7FF;

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ### rtl/cfg_word.sv
// one 16-bit software register with byte strobes and a reset value.
// assumes a single write enable pulse per bus write on the same clock.
`default_nettype none

module cfg_word
    import seq_cfg_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    input  wire logic              ref_clk_in,
    input  wire logic              reset_in,
    input  wire logic              wr_en_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic [1:0]        wr_strb_in,
    output logic      [DATA_W-1:0] value_out
);

    typedef struct packed {
        logic [DATA_W-1:0] value;
    } word_state_t;

    word_state_t state_r;
    word_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        for (int b = 0; b < 2; b++) begin
            if (wr_en_in && wr_strb_in[b]) begin
                state_nxt.value[b*BYTE_W +: BYTE_W] = wr_data_in[b*BYTE_W +: BYTE_W];
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= '{value: RESET_VALUE};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign value_out = state_r.value;

endmodule

`default_nettype wire

// ### rtl/readout_delay_timer.sv
// holds off the start of line readout for a programmed number of clocks after
// the row overhead phase ends.
// assumes row_overhead_done_in is a one-cycle pulse on the same clock.
`default_nettype none

module readout_delay_timer
    import seq_cfg_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              reset_in,
    input  wire logic              row_overhead_done_in,
    input  wire logic              delay_enable_in,
    input  wire logic [BYTE_W-1:0] delay_cycles_in,
    output logic                   readout_start_out,
    output logic                   busy_out
);

    typedef struct packed {
        logic              busy;
        logic              go;
        logic [BYTE_W-1:0] count;
    } timer_state_t;

    timer_state_t state_r;
    timer_state_t state_nxt;

    always_comb begin
        state_nxt    = state_r;
        state_nxt.go = 1'b0;
        if (state_r.busy) begin
            // a new row end while waiting is dropped: one readout per row
            if (state_r.count == 8'h01) begin
                state_nxt.busy = 1'b0;
                state_nxt.go   = 1'b1;
            end
            state_nxt.count = state_r.count - 8'h01;
        end else if (row_overhead_done_in) begin
            if (delay_enable_in && delay_cycles_in != 8'h00) begin
                state_nxt.busy  = 1'b1;
                state_nxt.count = delay_cycles_in;
            end else begin
                state_nxt.go = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign readout_start_out = state_r.go;
    assign busy_out          = state_r.busy;

    wait_holds_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state_r.busy && state_r.count > 8'h01 |=> !readout_start_out && busy_out)
        else $error("readout started before the delay ran out");

    wait_ends_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state_r.busy && state_r.count == 8'h01 |=> readout_start_out && !busy_out)
        else $error("readout did not start when the delay ran out");

    no_delay_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        row_overhead_done_in && !busy_out && !delay_enable_in |=> readout_start_out)
        else $error("delay applied while disabled");

endmodule

`default_nettype wire

// ### rtl/sensor_sequencer_config.sv
// configuration register bank of the frame sequencer, reached over AXI4-Lite,
// with the readout hold-off timer and the settings fanned out to the sequencer.
// assumes one clock; row_overhead_done_in comes from sequencer logic on that clock.
//
// What this block does
// - with the readout-delay enable set, readout waits a programmed time after row overhead ends.
// - the high byte of the delay register is that wait, used only while the enable is one.
// - general bit 7 selects subsampled readout.
// - general bit 8 selects binning.
// - general bit 10 limits exposure statistics to the configured window.
// - general bits 13:11 choose what drives the monitor pins.
// - in rolling shutter the low byte of the delay register lengthens each line.
// - integration bit 0 enables dual slope, in global shutter only.
// - integration bit 1 enables triple slope, in global shutter only.
// - integration bit 2, reset to one, reads the span value as frame length, else reset length.
// - dark row count sets black lines per frame, 1 to 255, default 2.
// - dark row bit 8, default one, blanks the first output line.
// - padding row field sets 0 to 2047 dummy lines, rolling shutter only.
// - general bit 1 selects global (0) or rolling (1) shutter.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none

module sensor_sequencer_config
    import seq_cfg_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk_in,
    input  wire logic              reset_in,
    input  wire logic [ADDR_W-1:0] awaddr_in,
    input  wire logic              awvalid_in,
    output logic                   awready_out,
    input  wire logic [31:0]       wdata_in,
    input  wire logic [3:0]        wstrb_in,
    input  wire logic              wvalid_in,
    output logic                   wready_out,
    output logic [1:0]             bresp_out,
    output logic                   bvalid_out,
    input  wire logic              bready_in,
    input  wire logic [ADDR_W-1:0] araddr_in,
    input  wire logic              arvalid_in,
    output logic                   arready_out,
    output logic [31:0]            rdata_out,
    output logic [1:0]             rresp_out,
    output logic                   rvalid_out,
    input  wire logic              rready_in,
    input  wire logic              row_overhead_done_in,
    output logic                   readout_start_out,
    output logic                   readout_wait_busy_out,
    output logic                   seq_enable_out,
    output logic                   rolling_shutter_out,
    output logic                   subsample_out,
    output logic                   binning_out,
    output logic                   aec_window_only_out,
    output logic [MON_W-1:0]       monitor_select_out,
    output logic [1:0]             monitor_out,
    output logic [BYTE_W-1:0]      line_readout_extension_out,
    output logic                   dual_slope_out,
    output logic                   triple_slope_out,
    output logic                   length_interpretation_sel_out,
    output logic [BYTE_W-1:0]      window_select_out,
    output logic [BYTE_W-1:0]      dark_row_count_out,
    output logic                   blank_first_line_out,
    output logic [PAD_W-1:0]       padding_row_count_out
);

    // refused while elaborating: the word index and the byte lanes must both fit the address
    if (ADDR_W < IDX_W + 2 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 32");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              seq_enable;
        logic              rolling;
        logic              subsample;
        logic              binning;
        logic              aec_window;
        logic [MON_W-1:0]  mon_sel;
        logic [1:0]        mon;
        logic [BYTE_W-1:0] line_ext;
        logic              dual;
        logic              triple;
        logic              len_sel;
        logic [BYTE_W-1:0] window;
        logic [BYTE_W-1:0] dark_count;
        logic              blank_first;
        logic [PAD_W-1:0]  pad_count;
    } cfg_state_t;

    cfg_state_t state_r;
    cfg_state_t state_nxt;

    logic [DATA_W-1:0] words [REG_COUNT];
    logic [REG_COUNT-1:0] word_wr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [1:0]        wr_strb;
    logic              timer_go;
    logic              timer_busy;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a[ADDR_W-1:2] < (ADDR_W-2)'(REG_COUNT)) && (a[1:0] == 2'h0);
    endfunction

    // ----------------------------------------------------------------
    // register words
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_TABLE [REG_COUNT] = '{RST_GENERAL, RST_DELAY, RST_INTEG,
                                                           RST_WINDOW, RST_SPARE, RST_DARK, RST_PADDING};

    // every bit is stored, reserved ones included, so readback matches the write
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_word
        cfg_word #(
            .RESET_VALUE (RST_TABLE[i])
        ) u_word (
            .ref_clk_in  (ref_clk_in),
            .reset_in    (reset_in),
            .wr_en_in    (word_wr[i]),
            .wr_data_in  (wr_data),
            .wr_strb_in  (wr_strb),
            .value_out   (words[i])
        );
    end

    readout_delay_timer u_timer (
        .ref_clk_in           (ref_clk_in),
        .reset_in             (reset_in),
        .row_overhead_done_in (row_overhead_done_in),
        .delay_enable_in      (words[IDX_GENERAL][GEN_DELAY_EN_BIT]),
        .delay_cycles_in      (words[IDX_DELAY][DLY_WAIT_LSB +: BYTE_W]),
        .readout_start_out    (timer_go),
        .busy_out             (timer_busy)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic aw_take;
        logic w_take;
        logic rolling;
        logic [BYTE_W-1:0] dark;
        logic [PAD_W-1:0]  pad;
        aw_take   = awvalid_in && state_r.awready;
        w_take    = wvalid_in && state_r.wready;
        rolling   = words[IDX_GENERAL][GEN_ROLLING_BIT];
        dark      = words[IDX_DARK][DARK_COUNT_LSB +: BYTE_W];
        pad       = words[IDX_PADDING][PAD_LSB +: PAD_W];
        state_nxt = state_r;
        word_wr   = '0;

        // write channel: address and data accepted in either order
        if (aw_take) begin
            state_nxt.aw_got = 1'b1;
            state_nxt.waddr  = awaddr_in;
        end
        if (w_take) begin
            state_nxt.w_got = 1'b1;
            state_nxt.wdata = wdata_in[DATA_W-1:0];
            state_nxt.wstrb = wstrb_in[1:0];
        end
        wr_addr = state_nxt.waddr;
        wr_data = state_nxt.wdata;
        wr_strb = state_nxt.wstrb;
        if (state_r.bvalid && bready_in) begin
            state_nxt.bvalid = 1'b0;
        end
        if (state_nxt.aw_got && state_nxt.w_got && !state_r.bvalid) begin
            state_nxt.aw_got = 1'b0;
            state_nxt.w_got  = 1'b0;
            state_nxt.bvalid = 1'b1;
            if (mapped(wr_addr)) begin
                word_wr[wr_addr[IDX_W+1:2]] = 1'b1;
                state_nxt.bresp = RESP_OKAY;
            end else begin
                state_nxt.bresp = RESP_SLVERR;
            end
        end
        state_nxt.awready = !state_nxt.aw_got && !state_nxt.bvalid;
        state_nxt.wready  = !state_nxt.w_got && !state_nxt.bvalid;

        // read channel: one read in flight
        if (state_r.rvalid && rready_in) begin
            state_nxt.rvalid = 1'b0;
        end
        if (arvalid_in && state_r.arready) begin
            state_nxt.rvalid = 1'b1;
            if (mapped(araddr_in)) begin
                state_nxt.rdata = {16'h0000, words[araddr_in[IDX_W+1:2]]};
                state_nxt.rresp = RESP_OKAY;
            end else begin
                state_nxt.rdata = 32'h0000_0000;
                state_nxt.rresp = RESP_SLVERR;
            end
        end
        state_nxt.arready = !state_nxt.rvalid;

        // settings seen by the sequencer
        state_nxt.seq_enable  = words[IDX_GENERAL][GEN_ENABLE_BIT];
        state_nxt.rolling     = rolling;
        state_nxt.subsample   = words[IDX_GENERAL][GEN_SUBSAMPLE_BIT];
        state_nxt.binning     = words[IDX_GENERAL][GEN_BINNING_BIT];
        state_nxt.aec_window  = words[IDX_GENERAL][GEN_AEC_WIN_BIT];
        state_nxt.mon_sel     = words[IDX_GENERAL][GEN_MON_LSB +: MON_W];
        state_nxt.line_ext    = rolling ? words[IDX_DELAY][DLY_EXT_LSB +: BYTE_W] : 8'h00;
        state_nxt.dual        = words[IDX_INTEG][INT_DUAL_BIT] && !rolling;
        state_nxt.triple      = words[IDX_INTEG][INT_TRIPLE_BIT] && !rolling;
        state_nxt.len_sel     = words[IDX_INTEG][INT_LEN_SEL_BIT];
        state_nxt.window      = words[IDX_WINDOW][WIN_LSB +: BYTE_W];
        // zero is out of range; the sequencer always needs one dark row
        state_nxt.dark_count  = (dark < DARK_MIN) ? DARK_MIN : dark;
        state_nxt.blank_first = words[IDX_DARK][DARK_BLANK_BIT];
        state_nxt.pad_count   = !rolling ? 12'h000 : ((pad > PAD_MAX) ? PAD_MAX : pad);

        // monitor pins: the selection picks a pair of internal signals
        case (words[IDX_GENERAL][GEN_MON_LSB +: MON_W])
            3'h1:    state_nxt.mon = {timer_go, timer_busy};
            3'h2:    state_nxt.mon = {row_overhead_done_in, timer_go};
            3'h3:    state_nxt.mon = {rolling, words[IDX_GENERAL][GEN_ENABLE_BIT]};
            default: state_nxt.mon = 2'h0;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r             <= '0;
            state_r.len_sel     <= RST_INTEG[INT_LEN_SEL_BIT];
            state_r.window      <= RST_WINDOW[WIN_LSB +: BYTE_W];
            state_r.dark_count  <= RST_DARK[DARK_COUNT_LSB +: BYTE_W];
            state_r.blank_first <= RST_DARK[DARK_BLANK_BIT];
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign awready_out                   = state_r.awready;
    assign wready_out                    = state_r.wready;
    assign bvalid_out                    = state_r.bvalid;
    assign bresp_out                     = state_r.bresp;
    assign arready_out                   = state_r.arready;
    assign rvalid_out                    = state_r.rvalid;
    assign rdata_out                     = state_r.rdata;
    assign rresp_out                     = state_r.rresp;
    assign readout_start_out             = timer_go;
    assign readout_wait_busy_out         = timer_busy;
    assign seq_enable_out                = state_r.seq_enable;
    assign rolling_shutter_out           = state_r.rolling;
    assign subsample_out                 = state_r.subsample;
    assign binning_out                   = state_r.binning;
    assign aec_window_only_out           = state_r.aec_window;
    assign monitor_select_out            = state_r.mon_sel;
    assign monitor_out                   = state_r.mon;
    assign line_readout_extension_out    = state_r.line_ext;
    assign dual_slope_out                = state_r.dual;
    assign triple_slope_out              = state_r.triple;
    assign length_interpretation_sel_out = state_r.len_sel;
    assign window_select_out             = state_r.window;
    assign dark_row_count_out            = state_r.dark_count;
    assign blank_first_line_out          = state_r.blank_first;
    assign padding_row_count_out         = state_r.pad_count;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    subsample_follow_a: assert property (subsample_out == $past(words[IDX_GENERAL][GEN_SUBSAMPLE_BIT]))
        else $error("subsample output does not follow its bit");
    binning_follow_a: assert property (binning_out == $past(words[IDX_GENERAL][GEN_BINNING_BIT]))
        else $error("binning output does not follow its bit");
    aec_window_a: assert property (aec_window_only_out == $past(words[IDX_GENERAL][GEN_AEC_WIN_BIT]))
        else $error("statistics window output does not follow its bit");
    dual_global_a: assert property (!(dual_slope_out && rolling_shutter_out))
        else $error("dual slope active in rolling shutter");
    triple_global_a: assert property (!(triple_slope_out && rolling_shutter_out))
        else $error("triple slope active in rolling shutter");
    line_ext_gate_a: assert property (!rolling_shutter_out |-> line_readout_extension_out == 8'h00)
        else $error("line extension applied in global shutter");
    dark_min_a: assert property (dark_row_count_out != 8'h00)
        else $error("dark row count fell to zero");
    pad_range_a: assert property (padding_row_count_out <= PAD_MAX &&
        (rolling_shutter_out || padding_row_count_out == 12'h000))
        else $error("padding rows out of range or outside rolling shutter");
    len_sel_write_a: assert property (word_wr[IDX_INTEG] && wr_strb[0]
        |=> ##1 length_interpretation_sel_out == $past(wr_data[INT_LEN_SEL_BIT], 2))
        else $error("length interpretation select missed its write");
    bresp_hold_a: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("write answer dropped before it was taken");

endmodule

`default_nettype wire

// ### test/tb.sv
// bench for the sequencer configuration bank: bus tasks and directed tests.
// assumes seq_cfg_pkg and sensor_sequencer_config are compiled before it.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import seq_cfg_pkg::*;
    // ------------------------------------------------------------
    // clock, reset and design
    // ------------------------------------------------------------
    logic        ref_clk = 0, reset_in = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, done = 0;
    logic        awready, wready, bvalid, arready, rvalid, start, busy, en, roll, sub, bin, aec, dual, trip, lsel, blank;
    logic [7:0]  awaddr = 0, araddr = 0, ext, win, dark;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 0;
    logic [1:0]  bresp, rresp, mon;
    logic [2:0]  msel;
    logic [11:0] pad;
    logic [15:0] rv [7] = '{RST_GENERAL, RST_DELAY, RST_INTEG, RST_WINDOW, RST_SPARE, RST_DARK, RST_PADDING};
    int          failures = 0, n_tests = 0, cyc = 0, n, nb;
    always #2 ref_clk = ~ref_clk;
    sensor_sequencer_config u_dut (.ref_clk_in(ref_clk), .reset_in(reset_in), .awaddr_in(awaddr),
        .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
        .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr),
        .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
        .rready_in(rready), .row_overhead_done_in(done), .readout_start_out(start), .readout_wait_busy_out(busy),
        .seq_enable_out(en), .rolling_shutter_out(roll), .subsample_out(sub), .binning_out(bin),
        .aec_window_only_out(aec), .monitor_select_out(msel), .monitor_out(mon), .line_readout_extension_out(ext),
        .dual_slope_out(dual), .triple_slope_out(trip), .length_interpretation_sel_out(lsel),
        .window_select_out(win), .dark_row_count_out(dark), .blank_first_line_out(blank),
        .padding_row_count_out(pad));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        bit pa, pd;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        {awvalid, wvalid} <= 2'h3;
        pa = 1;
        pd = 1;
        while (pa || pd) begin
            @(posedge ref_clk);
            pa = pa && !awready;
            pd = pd && !wready;
            awvalid <= pa;
            wvalid <= pd;
        end
        // bready comes late on purpose, so the answer must stand for a cycle
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge ref_clk);
        chk({bvalid, bresp}, {1'b1, er});
        bready <= 1'b0;
        // settings lag the word by a clock, so let two edges pass before anyone looks
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        chk(rdata, {16'h0000, e});
        chk(rresp, er);
        rready <= 1'b0;
    endtask
    task automatic pulse();
        @(posedge ref_clk) done <= 1'b1;
        @(posedge ref_clk) done <= 1'b0;
        n = 0;
        nb = 0;
        do begin
            @(posedge ref_clk);
            n++;
            nb += busy + mon[0];
        end while (start !== 1'b1 && n < 20);
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_in <= 1'b0;
        chk({lsel, blank, dark}, 10'h302);
        for (int i = 0; i < 7; i++) rd(8'(4 * i), rv[i], RESP_OKAY);
        $display("reset values done");
        wr(8'h00, 16'h5DC1, RESP_OKAY);
        rd(8'h00, 16'h5DC1, RESP_OKAY);
        chk({en, sub, bin, aec, msel, roll, mon}, 10'h3D9);
        wr(8'h04, 16'h0210, RESP_OKAY);
        wr(8'h08, 16'h0003, RESP_OKAY);
        wr(8'h18, 16'h0FFF, RESP_OKAY);
        chk({dual, trip, lsel, ext, pad}, 23'h600000);
        wr(8'h00, 16'h4DC3, RESP_OKAY);
        chk({dual, trip, roll, ext, pad}, 23'h1107FF);
        $display("shutter modes done");
        pulse();
        chk({n[3:0], nb[3:0]}, 8'h34);
        wr(8'h04, 16'h0010, RESP_OKAY);
        pulse();
        chk({n[3:0], nb[3:0]}, 8'h10);
        wr(8'h04, 16'h0210, RESP_OKAY);
        wr(8'h00, 16'h5D83, RESP_OKAY);
        pulse();
        chk({n[3:0], nb[3:0]}, 8'h11);
        $display("readout delay done");
        wr(8'h14, 16'h0000, RESP_OKAY);
        chk({blank, dark}, 9'h001);
        wr(8'h14, 16'h00FF, RESP_OKAY);
        chk(dark, 8'hFF);
        wr(8'h0C, 16'h0055, RESP_OKAY);
        chk(win, 8'h55);
        wr(8'h10, 16'hA5A5, RESP_OKAY);
        rd(8'h10, 16'hA5A5, RESP_OKAY);
        wr(8'h1C, 16'h1234, RESP_SLVERR);
        rd(8'h1C, 16'h0000, RESP_SLVERR);
        rd(8'h05, 16'h0000, RESP_SLVERR);
        $display("line counts and errors done");
        final_report();
    end
endmodule
`default_nettype wire
